// ===== core/cpdd_pkg.sv
// package of constants and types for the cpu/pci/dram datapath link
// Summary of operation
// - memory bus input on read, driven on write
// - drive pci ad only while enable low
// - even parity output reflects sampled ad
// - odd parity output reports ad parity
// - increment strobe advances eight-entry buffer pointer
// - decrement strobe moves buffer pointer back
// - three-bit control code steers data paths
// - shared burst bus meaning depends on phase
// - controller flags pci master cycles low-active
// - pci side and link share the one local clock
// - pci transaction: address phase then data phases
// - initiator frame marks start and length
// - full 64-bit processor data bus carried
// - ad lines double as config device selects
// - names ending _n are active low
// - private link timed by interface clock
package cpdd_pkg;
  localparam int CPDD_CPU_W = 64;
  localparam int CPDD_MEM_W = 64;
  localparam int CPDD_AD_W = 32;
  localparam int CPDD_BURST_W = 8;
  localparam int CPDD_WBUF_DEPTH = 8;
  localparam int CPDD_PTR_W = 3;
  localparam logic [2:0] CPDD_PTR_RST = 3'h0;
  localparam logic [63:0] CPDD_DATA_RST = 64'h0;

  // datapath operation codes
  typedef enum logic [2:0] {
    CPDD_OP_IDLE = 3'b000,
    CPDD_OP_CPU_TO_MEM = 3'b001,
    CPDD_OP_MEM_TO_CPU = 3'b010,
    CPDD_OP_CPU_TO_PCI = 3'b011,
    CPDD_OP_PCI_TO_CPU = 3'b100,
    CPDD_OP_PCI_TO_MEM = 3'b101,
    CPDD_OP_MEM_TO_PCI = 3'b110,
    CPDD_OP_BURST_OUT = 3'b111
  } cpdd_op_t;
endpackage : cpdd_pkg

// ===== core/cpdd_link_if.sv
// interface joining the controller end and the datapath end
`timescale 1ns/1ps
interface cpdd_link_if;
  import cpdd_pkg::*;
  logic [2:0] datapath_control_code;
  logic wbuf_ptr_up;
  logic wbuf_ptr_down;
  logic ad_drive_enable_n;
  logic pci_master_cycle_n;
  logic ad_parity_even_out;
  logic ad_parity_odd_out;
  logic [7:0] burst_ctl_o;
  logic burst_ctl_oe;
  logic [7:0] burst_dp_o;
  logic burst_dp_oe;
  logic [7:0] burst_side_bus;
  // wire level of the shared burst bus worked out from both enables
  assign burst_side_bus = burst_ctl_oe ? burst_ctl_o : (burst_dp_oe ? burst_dp_o : 8'h00);
  modport ctl (
    output datapath_control_code, wbuf_ptr_up, wbuf_ptr_down, ad_drive_enable_n, pci_master_cycle_n,
    output burst_ctl_o, burst_ctl_oe,
    input ad_parity_even_out, ad_parity_odd_out, burst_side_bus
  );
  modport dp (
    input datapath_control_code, wbuf_ptr_up, wbuf_ptr_down, ad_drive_enable_n, pci_master_cycle_n,
    output burst_dp_o, burst_dp_oe,
    output ad_parity_even_out, ad_parity_odd_out,
    input burst_side_bus
  );
endinterface : cpdd_link_if

// ===== core/cpdd_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module cpdd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } cpdd_fifo_st_t;
  cpdd_fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = mem[st_r.rd];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = st_r.wr + AW'(1);
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + AW'(1);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wr] <= in_data;
    end
  end
endmodule : cpdd_fifo

// ===== core/cpdd_datapath.sv
// datapath end: steers cpu, memory and pci data under controller code
`timescale 1ns/1ps
module cpdd_datapath
  import cpdd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  cpdd_link_if.dp link,
  input wire logic [63:0] cpu_data_in,
  output logic [63:0] cpu_data_out,
  output logic cpu_data_oe,
  input wire logic [63:0] memory_data_bus_in,
  output logic [63:0] memory_data_bus_out,
  output logic memory_data_bus_oe,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [2:0] wbuf_ptr,
  output logic wbuf_full
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] ptr;
    logic [63:0] cpu_q;
    logic [63:0] mem_q;
    logic [31:0] ad_q;
    logic [31:0] ad_samp;
    logic par_even;
    logic par_odd;
    logic [7:0] burst_q;
  } cpdd_dp_st_t;
  cpdd_dp_st_t st_r, st_nxt;
  cpdd_op_t op;
  logic wb_in_valid, wb_in_ready, wb_out_valid, wb_out_ready;
  logic [63:0] wb_out_data;
  logic [3:0] wb_level;
  logic op_mem_write;
  logic op_cpu_drive;
  logic op_drain;
  logic op_burst_answer;
  logic strobe_up_only;
  logic strobe_down_only;
  logic ptr_advance;
  logic ptr_retreat;
  logic [31:0] cpu_half;
  logic [63:0] ad_pair;
  logic [63:0] drain_word;
  logic [63:0] burst_wide;
  logic ad_xor;

  // ****************************************
  // operation decode
  // ****************************************
  // decode control code
  assign op = cpdd_op_t'(link.datapath_control_code);
  assign op_mem_write = (op == CPDD_OP_CPU_TO_MEM) || (op == CPDD_OP_PCI_TO_MEM);
  assign op_cpu_drive = (op == CPDD_OP_MEM_TO_CPU) || (op == CPDD_OP_PCI_TO_CPU) || (op == CPDD_OP_BURST_OUT);
  // only a cpu-to-memory write empties the write buffer
  assign op_drain = (op == CPDD_OP_CPU_TO_MEM);
  assign op_burst_answer = !link.pci_master_cycle_n && (op == CPDD_OP_MEM_TO_PCI);

  // ****************************************
  // pointer strobes
  // ****************************************
  // both strobes cancel
  assign strobe_up_only = link.wbuf_ptr_up && !link.wbuf_ptr_down;
  assign strobe_down_only = link.wbuf_ptr_down && !link.wbuf_ptr_up;
  // advance unless full
  // a refused push must not move the pointer, or pointer and buffer part ways
  assign ptr_advance = strobe_up_only && wb_in_ready;
  // step back one
  // the pointer wraps modulo eight in both directions
  assign ptr_retreat = strobe_down_only;

  // ****************************************
  // write buffer between cpu and memory
  // ****************************************
  // cpu writes queue here; the memory side drains only on a cpu-to-memory write op,
  // so a long phase without that op really fills it and stalls cpu ingest
  // a push offered while full is dropped; the controller must watch wbuf_full
  assign wb_in_valid = strobe_up_only;
  assign wb_out_ready = op_drain;
  assign wbuf_full = (wb_level == 4'(CPDD_WBUF_DEPTH));

  cpdd_fifo #(.WIDTH(CPDD_CPU_W), .DEPTH(CPDD_WBUF_DEPTH)) u_wbuf (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(wb_in_valid),
    .in_ready(wb_in_ready),
    .in_data(cpu_data_in),
    .out_valid(wb_out_valid),
    .out_ready(wb_out_ready),
    .out_data(wb_out_data),
    .level(wb_level)
  );

  // ****************************************
  // source words
  // ****************************************
  // one ad word per phase
  // an even pointer picks the lower half of the cpu word, an odd one the upper
  assign cpu_half = st_r.ptr[0] ? cpu_data_in[63:32] : cpu_data_in[31:0];
  // the 32-bit pci word lands on both halves of the wide buses
  for (genvar h = 0; h < 2; h++) begin : g_ad_half
    assign ad_pair[h*32 +: 32] = st_r.ad_samp;
  end
  // a buffered word goes first; an empty buffer passes the cpu word on
  assign drain_word = wb_out_valid ? wb_out_data : cpu_data_in;
  assign burst_wide = {56'h0, link.burst_side_bus};
  // parity of ad lines
  // even and odd outputs share one xor so they never disagree once out of reset
  assign ad_xor = ^ad_in;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (ptr_advance) begin
      st_nxt.ptr = st_r.ptr + 3'h1;
    end else if (ptr_retreat) begin
      st_nxt.ptr = st_r.ptr - 3'h1;
    end
    st_nxt.ad_samp = ad_in;
    st_nxt.par_even = ad_xor;
    st_nxt.par_odd = ~ad_xor;
    st_nxt.burst_q = link.burst_side_bus;
    case (op)
      CPDD_OP_CPU_TO_MEM: begin
        st_nxt.mem_q = drain_word;
      end
      CPDD_OP_MEM_TO_CPU: begin
        st_nxt.cpu_q = memory_data_bus_in;
      end
      CPDD_OP_CPU_TO_PCI: begin
        st_nxt.ad_q = cpu_half;
      end
      CPDD_OP_PCI_TO_CPU: begin
        st_nxt.cpu_q = ad_pair;
      end
      CPDD_OP_PCI_TO_MEM: begin
        st_nxt.mem_q = ad_pair;
      end
      CPDD_OP_MEM_TO_PCI: begin
        st_nxt.ad_q = memory_data_bus_in[31:0];
      end
      CPDD_OP_BURST_OUT: begin
        st_nxt.cpu_q = burst_wide;
      end
      default: begin
        // idle: cpu_q, mem_q and ad_q keep their words
        st_nxt.ad_q = st_r.ad_q;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // the write buffer clears its own pointers on the same reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r.ptr <= CPDD_PTR_RST;
      st_r.cpu_q <= CPDD_DATA_RST;
      st_r.mem_q <= CPDD_DATA_RST;
      st_r.ad_q <= CPDD_DATA_RST[31:0];
      st_r.ad_samp <= CPDD_DATA_RST[31:0];
      st_r.par_even <= CPDD_DATA_RST[0];
      st_r.par_odd <= CPDD_DATA_RST[0];
      st_r.burst_q <= CPDD_DATA_RST[7:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wbuf_ptr = st_r.ptr;
  // memory bus driven only on memory writes
  // the enable follows the code at once while the word lags by one edge,
  // so a write code must stand for two edges to put its own word out
  assign memory_data_bus_oe = op_mem_write;
  assign memory_data_bus_out = st_r.mem_q;
  assign cpu_data_oe = op_cpu_drive;
  assign cpu_data_out = st_r.cpu_q;
  // ad driven only while enable is low
  assign ad_oe = !link.ad_drive_enable_n;
  assign ad_out = st_r.ad_q;
  assign link.ad_parity_even_out = st_r.par_even;
  assign link.ad_parity_odd_out = st_r.par_odd;
  // datapath answers on burst bus during pci master reads
  assign link.burst_dp_oe = op_burst_answer;
  assign link.burst_dp_o = st_r.burst_q ^ {5'h0, st_r.ptr};
endmodule : cpdd_datapath

// ===== core/cpdd_controller.sv
// controller end: issues datapath codes and strobes over the link
`timescale 1ns/1ps
module cpdd_controller
  import cpdd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  cpdd_link_if.ctl link,
  input wire logic [2:0] req_code,
  input wire logic req_push,
  input wire logic req_pop,
  input wire logic req_drive_ad,
  input wire logic req_pci_master,
  input wire logic [7:0] req_burst,
  input wire logic req_burst_en,
  output logic parity_even_seen,
  output logic parity_odd_seen
);
  typedef struct packed {
    logic [2:0] code;
    logic up;
    logic down;
    logic ad_en_n;
    logic pm_n;
    logic [7:0] burst;
    logic burst_en;
    logic pe;
    logic po;
  } cpdd_ctl_st_t;
  cpdd_ctl_st_t st_r, st_nxt;

  always_comb begin
    st_nxt.code = req_code;
    st_nxt.up = req_push;
    st_nxt.down = req_pop;
    st_nxt.ad_en_n = !req_drive_ad;
    st_nxt.pm_n = !req_pci_master;
    st_nxt.burst = req_burst;
    st_nxt.burst_en = req_burst_en && req_pci_master == 1'b0;
    st_nxt.pe = link.ad_parity_even_out;
    st_nxt.po = link.ad_parity_odd_out;
  end

  // all link signals registered on the interface clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.ad_en_n <= 1'b1;
      st_r.pm_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.datapath_control_code = st_r.code;
  assign link.wbuf_ptr_up = st_r.up;
  assign link.wbuf_ptr_down = st_r.down;
  assign link.ad_drive_enable_n = st_r.ad_en_n;
  assign link.pci_master_cycle_n = st_r.pm_n;
  // controller drives burst bus outside pci master cycles
  assign link.burst_ctl_o = st_r.burst;
  assign link.burst_ctl_oe = st_r.burst_en;
  assign parity_even_seen = st_r.pe;
  assign parity_odd_seen = st_r.po;
endmodule : cpdd_controller

// ===== bench/cpdd_link_assertions.sv
// checker watching the link between controller and datapath
`timescale 1ns/1ps
module cpdd_link_assertions (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [2:0] datapath_control_code,
  input wire logic wbuf_ptr_up,
  input wire logic wbuf_ptr_down,
  input wire logic ad_drive_enable_n,
  input wire logic pci_master_cycle_n,
  input wire logic ad_parity_even_out,
  input wire logic ad_parity_odd_out,
  input wire logic [7:0] burst_ctl_o,
  input wire logic burst_ctl_oe,
  input wire logic [7:0] burst_dp_o,
  input wire logic burst_dp_oe,
  input wire logic [7:0] burst_side_bus
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // link properties
  // ****************************************
  // the first edge after release still shows values left by reset
  chk_parity_pair: assert property (!$past(srst) |-> ad_parity_odd_out == ~ad_parity_even_out)
    else $error("odd parity not inverse of even parity");
  chk_reset_enables: assert property ($fell(srst) |-> ad_drive_enable_n && pci_master_cycle_n)
    else $error("low-active link signals asserted after reset");
  chk_reset_strobes: assert property ($fell(srst) |-> !wbuf_ptr_up && !wbuf_ptr_down)
    else $error("pointer strobe active after reset");
  chk_reset_code: assert property ($fell(srst) |-> datapath_control_code == 3'h0)
    else $error("control code not idle after reset");
  chk_reset_parity: assert property ($fell(srst) |-> !ad_parity_even_out && !ad_parity_odd_out)
    else $error("parity outputs not cleared by reset");
  chk_bus_idle: assert property (!burst_ctl_oe && !burst_dp_oe |-> burst_side_bus == 8'h00)
    else $error("undriven burst bus not at idle level");
  chk_bus_ctl_value: assert property (burst_ctl_oe |-> burst_side_bus == burst_ctl_o)
    else $error("burst bus does not carry controller value");
  chk_bus_dp_value: assert property (burst_dp_oe && !burst_ctl_oe |-> burst_side_bus == burst_dp_o)
    else $error("burst bus does not carry datapath value");
  chk_ctl_gate: assert property (burst_ctl_oe |-> pci_master_cycle_n)
    else $error("controller drives burst bus in a master cycle");
endmodule : cpdd_link_assertions

// ===== bench/cpu_pci_dram_datapath_test.sv
// self-checking bench for controller and datapath joined by the link
`timescale 1ns/1ps
module cpu_pci_dram_datapath_test;
  import cpdd_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] req_code = 3'h0;
  logic req_push = 1'b0, req_pop = 1'b0, req_drive_ad = 1'b0, req_pci_master = 1'b0, req_burst_en = 1'b0;
  logic [7:0] req_burst = 8'h00;
  logic [63:0] cpu_data_in = 64'h0, memory_data_bus_in = 64'h0123456789ABCDEF, cpu_data_out, memory_data_bus_out;
  logic [31:0] ad_in = 32'h0, ad_out;
  logic cpu_data_oe, memory_data_bus_oe, ad_oe, wbuf_full, pe_seen, po_seen;
  logic [2:0] wbuf_ptr;
  int n_mismatch = 0, num_checks = 0;
  // link and pci side share one clock
  always #12.5 sys_clk = ~sys_clk;
  cpdd_link_if cpdd_link_if_i ();
  cpdd_controller cpdd_controller_i (.sys_clk(sys_clk), .srst(srst), .link(cpdd_link_if_i), .req_code(req_code),
    .req_push(req_push), .req_pop(req_pop), .req_drive_ad(req_drive_ad), .req_pci_master(req_pci_master),
    .req_burst(req_burst), .req_burst_en(req_burst_en), .parity_even_seen(pe_seen), .parity_odd_seen(po_seen));
  cpdd_datapath cpdd_datapath_i (.sys_clk(sys_clk), .srst(srst), .link(cpdd_link_if_i), .cpu_data_in(cpu_data_in),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe), .memory_data_bus_in(memory_data_bus_in),
    .memory_data_bus_out(memory_data_bus_out), .memory_data_bus_oe(memory_data_bus_oe), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .wbuf_ptr(wbuf_ptr), .wbuf_full(wbuf_full));
  cpdd_link_assertions cpdd_link_assertions_i (.sys_clk(sys_clk), .srst(srst),
    .datapath_control_code(cpdd_link_if_i.datapath_control_code), .wbuf_ptr_up(cpdd_link_if_i.wbuf_ptr_up),
    .wbuf_ptr_down(cpdd_link_if_i.wbuf_ptr_down), .ad_drive_enable_n(cpdd_link_if_i.ad_drive_enable_n),
    .pci_master_cycle_n(cpdd_link_if_i.pci_master_cycle_n), .ad_parity_even_out(cpdd_link_if_i.ad_parity_even_out),
    .ad_parity_odd_out(cpdd_link_if_i.ad_parity_odd_out), .burst_ctl_o(cpdd_link_if_i.burst_ctl_o),
    .burst_ctl_oe(cpdd_link_if_i.burst_ctl_oe), .burst_dp_o(cpdd_link_if_i.burst_dp_o),
    .burst_dp_oe(cpdd_link_if_i.burst_dp_oe), .burst_side_bus(cpdd_link_if_i.burst_side_bus));
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // strobes cross the controller register, then act one edge later
  task automatic stb(input logic u, input logic d, input logic [63:0] v);
    req_push = u;
    req_pop = d;
    cpu_data_in = v;
    cyc(1);
    req_push = 1'b0;
    req_pop = 1'b0;
    cyc(1);
  endtask : stb
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ptr;
    stb(1'b1, 1'b0, 64'h1111);
    stb(1'b1, 1'b0, 64'h2222);
    chk("ptr after two up", 64'(wbuf_ptr), 64'h2);
    stb(1'b0, 1'b1, 64'h0);
    chk("ptr after down", 64'(wbuf_ptr), 64'h1);
    stb(1'b1, 1'b1, 64'h3333);
    chk("ptr after both", 64'(wbuf_ptr), 64'h1);
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    chk("ptr after reset", 64'(wbuf_ptr), 64'h0);
    $display("pointer test done");
  endtask : t_ptr
  task automatic t_fill;
    for (int i = 0; i < 8; i++) begin
      stb(1'b1, 1'b0, 64'hA000 + 64'(i));
      chk("ptr during fill", 64'(wbuf_ptr), 64'((i + 1) % 8));
    end
    chk("full", 64'(wbuf_full), 64'h1);
    stb(1'b1, 1'b0, 64'hBEEF);
    chk("ptr when full", 64'(wbuf_ptr), 64'h0);
    req_code = 3'h1;
    cyc(1);
    chk("mem oe on write", 64'(memory_data_bus_oe), 64'h1);
    req_code = 3'h0;
    cyc(1);
    chk("mem data out", memory_data_bus_out, 64'hA000);
    chk("full after drain", 64'(wbuf_full), 64'h0);
    $display("fill test done");
  endtask : t_fill
  task automatic t_ad;
    req_drive_ad = 1'b1;
    cyc(1);
    chk("enable low", 64'(cpdd_link_if_i.ad_drive_enable_n), 64'h0);
    chk("ad driven", 64'(ad_oe), 64'h1);
    req_drive_ad = 1'b0;
    cyc(1);
    chk("ad released", 64'(ad_oe), 64'h0);
    $display("ad enable test done");
  endtask : t_ad
  task automatic t_par;
    logic [31:0] vals [4] = '{32'h0, 32'h1, 32'h80000003, 32'hFFFFFFFE};
    foreach (vals[i]) begin
      ad_in = vals[i];
      cyc(1);
      chk("even parity", 64'(cpdd_link_if_i.ad_parity_even_out), 64'(^vals[i]));
      chk("odd parity", 64'(cpdd_link_if_i.ad_parity_odd_out), 64'(~^vals[i]));
      cyc(1);
      chk("parity seen", 64'(pe_seen), 64'(^vals[i]));
      chk("odd parity seen", 64'(po_seen), 64'(~^vals[i]));
    end
    $display("parity test done");
  endtask : t_par
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      req_code = 3'(c);
      cyc(1);
      chk("cpu oe", 64'(cpu_data_oe), 64'(c == 2 || c == 4 || c == 7));
      chk("mem oe", 64'(memory_data_bus_oe), 64'(c == 1 || c == 5));
      if (c >= 2 && c <= 6) begin
        cyc(1);
        // pointer is even here, so code 3 takes the lower cpu half
        case (c)
          2: chk("cpu data", cpu_data_out, memory_data_bus_in);
          3: chk("ad from cpu", 64'(ad_out), 64'(cpu_data_in[31:0]));
          4: chk("cpu data", cpu_data_out, {ad_in, ad_in});
          5: chk("mem from ad", memory_data_bus_out, {ad_in, ad_in});
          default: chk("ad from mem", 64'(ad_out), 64'(memory_data_bus_in[31:0]));
        endcase
      end
    end
    req_code = 3'h0;
    $display("code test done");
  endtask : t_codes
  task automatic t_burst;
    cyc(1);
    req_burst = 8'hA5;
    req_burst_en = 1'b1;
    req_code = 3'h7;
    cyc(2);
    chk("burst bus", 64'(cpdd_link_if_i.burst_side_bus), 64'hA5);
    chk("burst to cpu", cpu_data_out, 64'hA5);
    req_pci_master = 1'b1;
    req_code = 3'h6;
    cyc(3);
    chk("master flag", 64'(cpdd_link_if_i.pci_master_cycle_n), 64'h0);
    chk("ctl released", 64'(cpdd_link_if_i.burst_ctl_oe), 64'h0);
    chk("dp drives", 64'(cpdd_link_if_i.burst_dp_oe), 64'h1);
    req_pci_master = 1'b0;
    req_burst_en = 1'b0;
    req_code = 3'h0;
    cyc(2);
    $display("burst test done");
  endtask : t_burst
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    cyc(8);
    srst = 1'b0;
    t_ptr();
    t_fill();
    t_ad();
    t_par();
    t_codes();
    t_burst();
    results();
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule : cpu_pci_dram_datapath_test
